// ===== bsc_pkg.sv
// Constants, tables and types for the six-step motor controller.
// Assumes a 25 MHz system clock and 10-bit converter results on the same clock.
package bsc_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int PWM_HZ = 20_000;
  localparam logic [10:0] PWM_PERIOD = 11'(CLK_HZ / PWM_HZ);
  localparam int MS_TIME_US = 1000;
  localparam int MS_CYC_DEF = CLK_HZ / 1_000_000 * MS_TIME_US;
  localparam int WDT_TIME_NS = 7_360_000;
  localparam int WDT_CYC_DEF = CLK_HZ / 1_000_000 * WDT_TIME_NS / 1000;
  localparam int POLE_PAIRS = 2;
  // One electrical turn per (60*f/pp) cycles at 1 rpm
  localparam logic [31:0] SPD_K = 32'(60 * (CLK_HZ / POLE_PAIRS));
  localparam logic [31:0] STEP_ACC = 32'(60 * (CLK_HZ / POLE_PAIRS) / 6);
  localparam logic [7:0] POT_CENTER = 8'h7F;
  localparam int POT_SPAN = 128;
  localparam int SPD_MAX = 3200;
  localparam logic [11:0] SPD_MIN_HALL = 12'd530;
  localparam logic [11:0] SPD_MIN_LESS = 12'd265;
  localparam logic [11:0] SPD_CHG = 12'd600;
  localparam logic [11:0] OL_RAMP = 12'h001;
  localparam logic [15:0] SPD_LIMIT = 16'd3900;
  localparam int VBUS_FS = 111;
  localparam int CODE_FS = 255;
  localparam int OV_V = 28;
  localparam int UV_V = 15;
  localparam logic [7:0] TIMEOUT_MS = 8'd200;
  localparam logic [7:0] ALIGN_MS = 8'd100;
  localparam logic [7:0] OL_VOLT = 8'h30;
  localparam logic [7:0] VMAX = 8'hFF;
  localparam int KP_SH = 4;
  localparam int KI_SH = 8;
  localparam logic signed [23:0] INT_LIM = 24'sh00FF00;
  localparam logic [2:0] NCAP_FULL = 3'h6;
  localparam logic [2:0] STEP_BAD = 3'h7;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_OC = 3'h1;
  localparam logic [2:0] ERR_OV = 3'h2;
  localparam logic [2:0] ERR_UV = 3'h3;
  localparam logic [2:0] ERR_OS = 3'h4;
  localparam logic [2:0] ERR_TO = 3'h5;
  localparam logic [2:0] ERR_PAT = 3'h6;
  localparam logic [2:0] ERR_WDT = 3'h7;

  typedef enum logic [1:0] {
    SYS_STOPPED = 2'b00, SYS_DRIVING = 2'b01, SYS_ERROR = 2'b10
  } bsc_sys_e;
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00, RUN_ALIGN = 2'b01, RUN_OPEN = 2'b10, RUN_PI = 2'b11
  } bsc_run_e;

  function automatic logic [2:0] bsc_inc(input logic [2:0] st);
    return (st == 3'h5) ? 3'h0 : st + 3'h1;
  endfunction

  function automatic logic [2:0] bsc_dec(input logic [2:0] st);
    return (st == 3'h0) ? 3'h5 : st - 3'h1;
  endfunction

  function automatic logic [2:0] bsc_hall_step(input logic [2:0] h);
    case (h)
      3'b001: return 3'h0;
      3'b011: return 3'h1;
      3'b010: return 3'h2;
      3'b110: return 3'h3;
      3'b100: return 3'h4;
      3'b101: return 3'h5;
      default: return STEP_BAD;
    endcase
  endfunction

  // Gate order {wh,wl,vh,vl,uh,ul}; high side chops, low side stays on
  function automatic logic [5:0] bsc_gate(input logic [2:0] st, input logic pwm_on);
    logic [1:0] hi;
    logic [1:0] lo;
    hi = (st < 3'h2) ? 2'd0 : (st < 3'h4) ? 2'd1 : 2'd2;
    lo = (st == 3'h0 || st == 3'h5) ? 2'd1 : (st < 3'h3) ? 2'd2 : 2'd0;
    return ({5'h00, pwm_on} << (2 * hi + 1)) | (6'h01 << (2 * lo));
  endfunction
endpackage

// ===== bsc_top.sv
// Six-step PMSM controller: speed command, sensing, PI loop, PWM and protection.
// Assumes converter results and user request pulses on clk_sys; Hall and overcurrent
// pins are asynchronous.
module bsc_top
  import bsc_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DEF,
  parameter int WDT_CYC = WDT_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [9:0] speed_cmd_channel,
  input wire logic [9:0] bus_volt_channel,
  input wire logic [9:0] phase_u_channel,
  input wire logic [9:0] phase_v_channel,
  input wire logic [9:0] phase_w_channel,
  input wire logic [2:0] hall_in,
  input wire logic oc_stop_n,
  input wire logic sensorless_mode,
  input wire logic user_stop,
  input wire logic user_drive,
  input wire logic user_reset,
  input wire logic wdt_clear,
  output logic [5:0] gate,
  output logic [1:0] sys_state,
  output logic [2:0] fault_code,
  output logic [15:0] speed_rpm,
  output logic [10:0] duty_cnt
);

  typedef struct packed {
    bsc_sys_e sys;
    bsc_run_e run;
    logic [2:0] hs1;
    logic [2:0] hs2;
    logic [2:0] hs3;
    logic [2:0] hall;
    logic oc1;
    logic oc2;
    logic oc3;
    logic oc;
    logic [2:0] step;
    logic [2:0] hstep;
    logic dir;
    logic [31:0] tmr;
    logic [5:0][31:0] caps;
    logic [2:0] ncap;
    logic [31:0] per;
    logic [14:0] msc;
    logic [7:0] tom;
    logic [7:0] alm;
    logic [31:0] acc;
    logic [11:0] ref_rpm;
    logic zcp;
    logic [15:0] speed;
    logic signed [23:0] integ;
    logic [7:0] vcmd;
    logic [10:0] duty;
    logic [10:0] pwc;
    logic [5:0] gate;
    logic [17:0] wdt;
    logic [2:0] err;
  } bsc_st_s;

  bsc_st_s s;
  bsc_st_s next_s;

  logic [7:0] pot8;
  logic [7:0] bus8;
  logic [7:0] ph8;
  logic [11:0] mag;
  logic [11:0] spd_min;
  logic tick;
  logic wdt_hit;
  logic comm;
  logic pat_err;
  logic sgn;
  logic [2:0] hs_new;
  logic [2:0] drv_step;
  logic [2:0] fcode;
  logic drive_ev;
  logic stop_ev;
  logic [31:0] quo;
  logic [31:0] dq;
  logic signed [16:0] errv;
  logic signed [23:0] isum;
  logic signed [23:0] vt;

  always_comb begin
    next_s = s;
    pot8 = speed_cmd_channel[9:2];
    bus8 = bus_volt_channel[9:2];
    ph8 = 8'h00;
    mag = 12'h000;
    spd_min = sensorless_mode ? SPD_MIN_LESS : SPD_MIN_HALL;
    tick = (s.msc == 15'(MS_CYC - 1));
    wdt_hit = (s.wdt == 18'(WDT_CYC - 1));
    comm = 1'b0;
    pat_err = 1'b0;
    sgn = 1'b0;
    hs_new = bsc_hall_step(s.hall);
    drv_step = s.step;
    fcode = ERR_NONE;
    quo = 32'h0;
    dq = 32'h0;
    errv = 17'sh0;
    isum = 24'sh0;
    vt = 24'sh0;

    // Three-stage sync; a change is taken once stages two and three agree
    next_s.hs1 = hall_in;
    next_s.hs2 = s.hs1;
    next_s.hs3 = s.hs2;
    if (s.hs2 == s.hs3) begin
      next_s.hall = s.hs3;
    end
    next_s.oc1 = oc_stop_n;
    next_s.oc2 = s.oc1;
    next_s.oc3 = s.oc2;
    if (s.oc2 == s.oc3) begin
      next_s.oc = ~s.oc3;
    end

    next_s.tmr = s.tmr + 32'h1;
    next_s.msc = tick ? 15'h0000 : s.msc + 15'h0001;
    next_s.pwc = (s.pwc == PWM_PERIOD - 11'h001) ? 11'h000 : s.pwc + 11'h001;
    if (wdt_clear) begin
      next_s.wdt = 18'h00000;
    end else if (!wdt_hit) begin
      next_s.wdt = s.wdt + 18'h00001;
    end

    // Signed speed command about the pot mid code
    if (pot8 >= POT_CENTER) begin
      mag = 12'(((32'(pot8 - POT_CENTER)) * SPD_MAX) / POT_SPAN);
      next_s.dir = 1'b1;
    end else begin
      mag = 12'(((32'(POT_CENTER - pot8)) * SPD_MAX) / POT_SPAN);
      next_s.dir = 1'b0;
    end
    drive_ev = user_drive | (mag > spd_min);
    stop_ev = user_stop | (mag < spd_min);

    // Floating phase of the present step, compared with half bus
    case (3'(s.step % 3'h3))
      3'h0: ph8 = phase_w_channel[9:2];
      3'h1: ph8 = phase_v_channel[9:2];
      default: ph8 = phase_u_channel[9:2];
    endcase
    sgn = ph8 > {1'b0, bus8[7:1]};

    if (s.sys == SYS_DRIVING) begin
      if (!sensorless_mode) begin
        if (hs_new == STEP_BAD) begin
          pat_err = 1'b1;
        end else if (hs_new != s.hstep) begin
          comm = 1'b1;
          if (hs_new != bsc_inc(s.hstep) && hs_new != bsc_dec(s.hstep)) begin
            pat_err = 1'b1;
          end
        end
      end else if (s.run == RUN_OPEN) begin
        if (s.acc + 32'(s.ref_rpm) >= STEP_ACC) begin
          next_s.acc = s.acc + 32'(s.ref_rpm) - STEP_ACC;
          comm = 1'b1;
        end else begin
          next_s.acc = s.acc + 32'(s.ref_rpm);
        end
      end else if (s.run == RUN_PI) begin
        // Blanking until the next millisecond tick after each step hides the switching edge
        next_s.zcp = sgn;
        if (s.tom != 8'h00 && sgn != s.zcp) begin
          comm = 1'b1;
        end
      end
    end
    if (hs_new != STEP_BAD) begin
      next_s.hstep = hs_new;
    end

    if (comm) begin
      next_s.step = s.dir ? bsc_inc(s.step) : bsc_dec(s.step);
      next_s.caps = {s.caps[4:0], s.tmr};
      if (s.ncap == NCAP_FULL) begin
        next_s.per = s.tmr - s.caps[5];
      end else if (s.ncap != 3'h0) begin
        next_s.per = 32'((s.tmr - s.caps[0]) * 6);
      end
      if (s.ncap != NCAP_FULL) begin
        next_s.ncap = s.ncap + 3'h1;
      end
      next_s.tom = 8'h00;
    end

    if (tick) begin
      if (!comm && s.tom != 8'hFF) begin
        next_s.tom = s.tom + 8'h01;
      end
      quo = (s.per == 32'h0) ? 32'hFFFFFFFF : SPD_K / s.per;
      if (s.ncap < 3'h2) begin
        next_s.speed = 16'h0000;
      end else begin
        next_s.speed = (quo > 32'h0000FFFF) ? 16'hFFFF : quo[15:0];
      end
      case (s.run)
        RUN_ALIGN: begin
          next_s.vcmd = OL_VOLT;
          next_s.alm = s.alm + 8'h01;
          if (s.alm == ALIGN_MS) begin
            next_s.run = RUN_OPEN;
            next_s.ref_rpm = spd_min;
            next_s.step = s.dir ? bsc_inc(s.step) : bsc_dec(s.step);
            next_s.tom = 8'h00;
          end
        end
        RUN_OPEN: begin
          next_s.ref_rpm = s.ref_rpm + OL_RAMP;
          if (s.ref_rpm >= SPD_CHG) begin
            next_s.run = RUN_PI;
            next_s.integ = 24'(OL_VOLT) <<< KI_SH;
          end
        end
        RUN_PI: begin
          errv = $signed({5'h00, mag}) - $signed({1'b0, s.speed});
          isum = s.integ + 24'(errv);
          if (isum > INT_LIM) begin
            isum = INT_LIM;
          end else if (isum < -INT_LIM) begin
            isum = -INT_LIM;
          end
          next_s.integ = isum;
          vt = 24'(errv >>> KP_SH) + (isum >>> KI_SH);
          if (vt < 24'sh0) begin
            next_s.vcmd = 8'h00;
          end else if (vt > 24'(VMAX)) begin
            next_s.vcmd = VMAX;
          end else begin
            next_s.vcmd = vt[7:0];
          end
        end
        default: next_s.vcmd = 8'h00;
      endcase
      // Modulation factor V/E scaled to the carrier period
      dq = (bus8 == 8'h00) ? 32'(PWM_PERIOD) : (32'(s.vcmd) * 32'(PWM_PERIOD)) / 32'(bus8);
      next_s.duty = (dq > 32'(PWM_PERIOD)) ? PWM_PERIOD : dq[10:0];
    end

    // Protection, highest priority first
    if (s.oc) begin
      fcode = ERR_OC;
    end else if (wdt_hit) begin
      fcode = ERR_WDT;
    end else if (s.sys == SYS_DRIVING) begin
      if (pat_err) begin
        fcode = ERR_PAT;
      end else if (tick && 32'(bus8) * VBUS_FS > OV_V * CODE_FS) begin
        fcode = ERR_OV;
      end else if (tick && 32'(bus8) * VBUS_FS < UV_V * CODE_FS) begin
        fcode = ERR_UV;
      end else if (tick && s.speed > SPD_LIMIT) begin
        fcode = ERR_OS;
      end else if (tick && s.run != RUN_ALIGN && s.tom >= TIMEOUT_MS) begin
        fcode = ERR_TO;
      end
    end

    case (s.sys)
      SYS_STOPPED: begin
        if (fcode != ERR_NONE) begin
          next_s.sys = SYS_ERROR;
          next_s.err = fcode;
        end else if (!stop_ev && drive_ev) begin
          next_s.sys = SYS_DRIVING;
          next_s.ncap = 3'h0;
          next_s.tom = 8'h00;
          next_s.alm = 8'h00;
          next_s.acc = 32'h0;
          next_s.integ = 24'sh0;
          next_s.speed = 16'h0000;
          next_s.step = 3'h0;
          next_s.vcmd = OL_VOLT;
          next_s.run = sensorless_mode ? RUN_ALIGN : RUN_PI;
        end
      end
      SYS_DRIVING: begin
        if (fcode != ERR_NONE) begin
          next_s.sys = SYS_ERROR;
          next_s.err = fcode;
          next_s.run = RUN_IDLE;
        end else if (stop_ev) begin
          next_s.sys = SYS_STOPPED;
          next_s.run = RUN_IDLE;
        end
      end
      SYS_ERROR: begin
        if (user_reset) begin
          next_s.sys = SYS_STOPPED;
          next_s.err = ERR_NONE;
          next_s.wdt = 18'h00000;
        end
      end
      default: next_s.sys = SYS_ERROR;
    endcase

    // Hall start takes the pattern from the live Hall code
    drv_step = sensorless_mode ? s.step : (s.dir ? s.hstep : bsc_inc(bsc_inc(bsc_inc(s.hstep))));
    if (next_s.sys == SYS_DRIVING && fcode == ERR_NONE) begin
      next_s.gate = bsc_gate(drv_step, s.pwc < s.duty);
    end else begin
      next_s.gate = 6'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.hs1 <= STEP_BAD;
      s.hs2 <= STEP_BAD;
      s.hs3 <= STEP_BAD;
      s.oc1 <= 1'b1;
      s.oc2 <= 1'b1;
      s.oc3 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign gate = s.gate;
  assign sys_state = s.sys;
  assign fault_code = s.err;
  assign speed_rpm = s.speed;
  assign duty_cnt = s.duty;

endmodule // bsc_top

// ===== bsc_chk.sv
// Checker for bsc_top: state, gate and protection relations.
// Sees only the bsc_top ports; bound at the foot of this file.
module bsc_chk
  import bsc_pkg::*;
#(
  parameter int WDT_CYC = WDT_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic oc_stop_n,
  input wire logic user_stop,
  input wire logic user_reset,
  input wire logic wdt_clear,
  input wire logic [5:0] gate,
  input wire logic [1:0] sys_state,
  input wire logic [2:0] fault_code,
  input wire logic [10:0] duty_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int wcnt;

  // Shadow watchdog; the margin of 4 covers register lag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wcnt <= 0;
    end else if (wdt_clear || (user_reset && sys_state == SYS_ERROR)) begin
      wcnt <= 0;
    end else if (wcnt < WDT_CYC + 8) begin
      wcnt <= wcnt + 1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // A reset request under a live fault passes through stopped for one cycle
  a_oc_gates_off: assert property (!oc_stop_n [*6] |-> gate == 6'h00 && (sys_state == SYS_ERROR || $past(user_reset)))
    else $error("gates live under overcurrent");
  a_err_gates_off: assert property (sys_state == SYS_ERROR ##1 sys_state == SYS_ERROR |-> gate == 6'h00)
    else $error("gates live in error");
  a_stop_gates_off: assert property (sys_state == SYS_STOPPED ##1 sys_state == SYS_STOPPED |-> gate == 6'h00)
    else $error("gates live while stopped");
  a_state_legal: assert property (sys_state != 2'b11)
    else $error("illegal system state");
  a_err_held: assert property (sys_state == SYS_ERROR && !user_reset |=> sys_state == SYS_ERROR)
    else $error("error left without reset");
  a_reset_clears: assert property (sys_state == SYS_ERROR && user_reset |=> sys_state == SYS_STOPPED)
    else $error("reset did not stop");
  a_code_held: assert property (sys_state == SYS_ERROR ##1 sys_state == SYS_ERROR |-> $stable(fault_code))
    else $error("fault code moved in error");
  a_leg_safe: assert property (!(gate[5] && gate[4]) && !(gate[3] && gate[2]) && !(gate[1] && gate[0]))
    else $error("shoot through on a leg");
  a_one_chop: assert property ($onehot0({gate[5], gate[3], gate[1]}))
    else $error("two high switches on");
  a_duty_range: assert property (duty_cnt <= PWM_PERIOD)
    else $error("duty beyond period");
  a_wdt_bite: assert property (wcnt == WDT_CYC + 4 |-> sys_state == SYS_ERROR)
    else $error("watchdog overflow missed");
  a_stop_acts: assert property (sys_state == SYS_DRIVING && user_stop |=> sys_state != SYS_DRIVING)
    else $error("stop request ignored");

  c_drive_fault: cover property (sys_state == SYS_DRIVING ##1 sys_state == SYS_ERROR);
  c_wdt: cover property (fault_code == ERR_WDT);
  c_reset: cover property (sys_state == SYS_ERROR && user_reset);
endmodule // bsc_chk

bind bsc_top bsc_chk #(.WDT_CYC(WDT_CYC)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .oc_stop_n(oc_stop_n), .user_stop(user_stop), .user_reset(user_reset),
  .wdt_clear(wdt_clear), .gate(gate), .sys_state(sys_state), .fault_code(fault_code),
  .duty_cnt(duty_cnt));

// ===== bsc_motor.sv
// Motor side model: Hall sensors and the external overcurrent circuit.
// Assumes the bench steers rotation, a broken sensor and overcurrent.
module bsc_motor #(
  parameter int STEP_CYC = 2000
) (
  input wire logic clk_sys,
  input wire logic spin,
  input wire logic bad,
  input wire logic oc,
  output logic [2:0] hall_in,
  output logic oc_stop_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] SEQ [6] = '{3'b001, 3'b011, 3'b010, 3'b110, 3'b100, 3'b101};
  logic [2:0] step = 3'h0;
  int cnt = 0;

  always @(posedge clk_sys) begin
    if (spin && cnt == STEP_CYC - 1) begin
      cnt <= 0;
      step <= (step == 3'h5) ? 3'h0 : step + 3'h1;
    end else if (spin) begin
      cnt <= cnt + 1;
    end
  end

  // A broken sensor reads all low
  assign hall_in = bad ? 3'b000 : SEQ[step];
  assign oc_stop_n = !oc;
endmodule // bsc_motor

// ===== bsc_tb.sv
// Self-checking bench for bsc_top with shortened ms tick and watchdog.
// Assumes bsc_motor as the far side and the bound checker.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bsc_pkg::*;
  localparam int MS = 50;
  localparam int WDT = 400;
  localparam logic [9:0] BUS_V [4] = '{10'h103, 10'h104, 10'h08F, 10'h088};
  localparam logic [2:0] BUS_F [4] = '{ERR_NONE, ERR_OV, ERR_NONE, ERR_UV};
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [9:0] pot = 10'h1FF;
  logic [9:0] bus = 10'h0DD;
  logic sless = 1'b0;
  logic [2:0] rq = 3'b000;
  logic wclr = 1'b0;
  logic wdt_en = 1'b1;
  logic spin = 1'b0;
  logic bad = 1'b0;
  logic oc = 1'b0;
  logic [2:0] hall;
  logic oc_n;
  logic [5:0] gate;
  logic [1:0] st;
  logic [2:0] fc;
  logic [15:0] rpm;
  logic [10:0] duty;
  int wc = 0;
  int n_errors = 0;
  int samples_checked = 0;

  always #20 clk_sys = ~clk_sys;

  bsc_motor mot (.clk_sys(clk_sys), .spin(spin), .bad(bad), .oc(oc), .hall_in(hall),
    .oc_stop_n(oc_n));
  bsc_top #(.MS_CYC(MS), .WDT_CYC(WDT)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .speed_cmd_channel(pot), .bus_volt_channel(bus), .phase_u_channel(10'h200),
    .phase_v_channel(10'h200), .phase_w_channel(10'h200), .hall_in(hall),
    .oc_stop_n(oc_n), .sensorless_mode(sless), .user_stop(rq[1]), .user_drive(rq[0]),
    .user_reset(rq[2]), .wdt_clear(wclr), .gate(gate), .sys_state(st), .fault_code(fc),
    .speed_rpm(rpm), .duty_cnt(duty));

  // Control loop feeds the watchdog unless a test starves it
  always @(posedge clk_sys) begin
    wc <= (wc == 99) ? 0 : wc + 1;
    wclr <= wdt_en && wc == 0;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One-cycle request pulse: bit 2 reset, bit 1 stop, bit 0 drive
  task automatic req(input logic [2:0] k);
    rq <= k;
    @(posedge clk_sys);
    rq <= 3'b000;
  endtask

  task automatic expect_st(input logic [1:0] s, input logic [2:0] f, input int lim);
    int i;
    i = 0;
    @(negedge clk_sys);
    while (st !== s && i < lim) begin
      @(negedge clk_sys);
      i++;
    end
    chk(16'(st), 16'(s));
    chk(16'(fc), 16'(f));
    @(posedge clk_sys);
  endtask

  task automatic lows(input logic [2:0] exp);
    cyc(4);
    @(negedge clk_sys);
    chk(16'({gate[4], gate[2], gate[0]}), 16'(exp));
    @(posedge clk_sys);
  endtask

  task automatic recover;
    spin <= 1'b0;
    bad <= 1'b0;
    oc <= 1'b0;
    bus <= 10'h0DD;
    pot <= 10'h1FF;
    cyc(6);
    req(3'b100);
    expect_st(SYS_STOPPED, ERR_NONE, 4);
  endtask

  task automatic t_start;
    @(negedge clk_sys);
    chk(16'(gate), 16'h0000);
    expect_st(SYS_STOPPED, ERR_NONE, 0);
    req(3'b001);
    cyc(3);
    expect_st(SYS_STOPPED, ERR_NONE, 0);
  endtask

  task automatic t_dir;
    pot <= 10'h3FF;
    expect_st(SYS_DRIVING, ERR_NONE, 4);
    lows(3'b010);
    cyc(3 * MS);
    @(negedge clk_sys);
    chk(rpm, 16'h0000);
    pot <= 10'h000;
    lows(3'b001);
    req(3'b010);
    pot <= 10'h1FF;
    expect_st(SYS_STOPPED, ERR_NONE, 4);
  endtask

  task automatic t_faults;
    pot <= 10'h3FF;
    spin <= 1'b1;
    expect_st(SYS_ERROR, ERR_OS, 8000);
    // Motor steps every 2000 cycles, so one electrical turn is six of them
    @(negedge clk_sys);
    chk(rpm, 16'(SPD_K / 32'(6 * 2000)));
    @(posedge clk_sys);
    recover;
    pot <= 10'h3FF;
    cyc(197 * MS);
    @(negedge clk_sys);
    chk(16'(st), 16'(SYS_DRIVING));
    expect_st(SYS_ERROR, ERR_TO, 5 * MS);
    recover;
    for (int i = 0; i < 4; i++) begin
      bus <= BUS_V[i];
      pot <= 10'h3FF;
      cyc(3 * MS);
      expect_st(BUS_F[i] == ERR_NONE ? SYS_DRIVING : SYS_ERROR, BUS_F[i], 0);
      recover;
    end
    pot <= 10'h3FF;
    cyc(6);
    bad <= 1'b1;
    expect_st(SYS_ERROR, ERR_PAT, 10);
    recover;
  endtask

  task automatic t_halt;
    pot <= 10'h3FF;
    cyc(6);
    oc <= 1'b1;
    expect_st(SYS_ERROR, ERR_OC, 8);
    req(3'b100);
    cyc(6);
    expect_st(SYS_ERROR, ERR_OC, 0);
    recover;
    wdt_en <= 1'b0;
    expect_st(SYS_ERROR, ERR_WDT, WDT + 20);
    wdt_en <= 1'b1;
    recover;
    sless <= 1'b1;
    cyc(2);
    pot <= 10'h3FF;
    expect_st(SYS_DRIVING, ERR_NONE, 4);
    cyc(4);
    @(negedge clk_sys);
    chk(16'($onehot({gate[4], gate[2], gate[0]})), 16'h0001);
    // Align voltage over the 8-bit bus code sets the duty after the next tick
    cyc(MS);
    @(negedge clk_sys);
    chk(16'(duty), 16'((32'(OL_VOLT) * 32'(PWM_PERIOD)) / 32'(10'h0DD >> 2)));
    @(posedge clk_sys);
    pot <= 10'h1FF;
    expect_st(SYS_STOPPED, ERR_NONE, 4);
    sless <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    cyc(2);
    arst_n <= 1'b1;
    cyc(6);
    t_start;
    t_dir;
    t_faults;
    t_halt;
    tally_and_finish;
  end

  // Whole run needs roughly 16k cycles
  initial begin
    cyc(60000);
    n_errors++;
    tally_and_finish;
  end
endmodule // tb
